// *** rtl/rxfd_regs.sv ***
// receive filter configuration, frame status and remote transfer pointer bank
// assumes host port and receive signals are synchronous to ref_clk_i
`timescale 1ns/1ps
`include "rxfd_cfg.svh"
module rxfd_regs (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  // host register port
  input  wire rxfd_pkg::rxfd_ofs_t  addr_i,
  input  wire logic             rd_i,
  input  wire logic             wr_i,
  input  wire rxfd_pkg::rxfd_byte_t wdata_i,
  output rxfd_pkg::rxfd_byte_t  rdata_o,
  // remote transfer control
  input  wire rxfd_pkg::rxfd_word_t origin_i,
  input  wire logic             start_i,
  input  wire logic             step_i,
  input  wire logic             word_i,
  output rxfd_pkg::rxfd_word_t  addr_o,
  output logic                  active_o,
  output logic                  done_o,
  // receive frame summary
  input  wire logic             frame_end_i,
  input  wire logic             own_addr_i,
  input  wire logic             unicast_i,
  input  wire logic             bcast_i,
  input  wire logic             mcast_i,
  input  wire logic             hash_hit_i,
  input  wire logic             short_i,
  input  wire logic             fcs_err_i,
  input  wire logic             align_err_i,
  input  wire logic             room_i,
  input  wire logic             rx_on_i,
  // receive decision
  output logic                  store_o,
  output logic                  drop_o
);
  import rxfd_pkg::*;

  // ==========================================
  // state
  rxfd_byte_t cfg_q, stat_q, stat_d, rdata_q, rdata_d;
  rxfd_word_t cnt_q, cnt_d, ptr_q, ptr_d;
  rxfd_dma_e  dma_q, dma_d;
  logic       done_q, done_d, store_q, drop_q;

  // ==========================================
  // host decode
  wire logic wr_cnt_lo = wr_i & (addr_i == `RXFD_OFS_CNT_LOW);
  wire logic wr_cnt_hi = wr_i & (addr_i == `RXFD_OFS_CNT_HIGH);
  wire logic wr_cfg    = wr_i & (addr_i == `RXFD_OFS_RX_CFG);
  wire logic wr_done   = wr_i & (addr_i == `RXFD_OFS_DONE) & wdata_i[`RXFD_DONE_BIT];

  // ==========================================
  // remote transfer
  wire logic [15:0] stride   = word_i ? 16'h0002 : 16'h0001;
  wire logic        last     = (cnt_q <= stride);
  wire logic        run_step = (dma_q == RXFD_DMA_RUN) & step_i;
  wire logic        finish   = (start_i & (cnt_q == `RXFD_RST_WORD)) | (run_step & last);

  always_comb begin
    dma_d = dma_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    if (wr_cnt_lo) begin
      cnt_d[7:0] = wdata_i;
    end
    if (wr_cnt_hi) begin
      cnt_d[15:8] = wdata_i;
    end
    unique case (dma_q)
      RXFD_DMA_IDLE: begin
        if (start_i) begin
          ptr_d = origin_i;
          if (cnt_q != `RXFD_RST_WORD) begin
            dma_d = RXFD_DMA_RUN;
          end
        end
      end
      RXFD_DMA_RUN: begin
        if (step_i) begin
          ptr_d = 16'(ptr_q + stride);
          cnt_d = last ? `RXFD_RST_WORD : 16'(cnt_q - stride);
          if (last) begin
            dma_d = RXFD_DMA_IDLE;
          end
        end
      end
    endcase
  end

  // a completion in the clearing cycle keeps the flag set
  assign done_d = finish | (done_q & ~wr_done);

  // ==========================================
  // frame filter
  logic match, keep;
  rxfd_addr_filter u_filter (
    .cfg_i      (cfg_q),
    .own_addr_i (own_addr_i),
    .unicast_i  (unicast_i),
    .bcast_i    (bcast_i),
    .mcast_i    (mcast_i),
    .hash_hit_i (hash_hit_i),
    .short_i    (short_i),
    .fault_i    (fcs_err_i | align_err_i),
    .room_i     (room_i),
    .rx_on_i    (rx_on_i),
    .match_o    (match),
    .store_o    (keep)
  );

  // status reflects the last frame that passed the address check or arrived with the receiver off
  always_comb begin
    stat_d = stat_q;
    if (frame_end_i & (match | ~rx_on_i)) begin
      stat_d                  = `RXFD_RST_BYTE;
      stat_d[`RXFD_ST_OFF]    = ~rx_on_i;
      stat_d[`RXFD_ST_MCAST]  = mcast_i;
      stat_d[`RXFD_ST_MISSED] = match & ~room_i;
      stat_d[`RXFD_ST_ALIGN]  = align_err_i;
      stat_d[`RXFD_ST_FCS]    = fcs_err_i;
      stat_d[`RXFD_ST_OK]     = match & ~fcs_err_i & ~align_err_i & ~short_i;
    end
  end

  // ==========================================
  // read mux, answered one cycle after the strobe
  always_comb begin
    rdata_d = `RXFD_RST_BYTE;
    unique case (addr_i)
      `RXFD_OFS_PTR_LOW:  rdata_d = ptr_q[7:0];
      `RXFD_OFS_PTR_HIGH: rdata_d = ptr_q[15:8];
      `RXFD_OFS_RX_STAT:  rdata_d = stat_q;
      `RXFD_OFS_DONE:     rdata_d[`RXFD_DONE_BIT] = done_q;
      default:            rdata_d = `RXFD_RST_BYTE;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q   <= `RXFD_RST_BYTE;
      stat_q  <= `RXFD_RST_BYTE;
      rdata_q <= `RXFD_RST_BYTE;
      cnt_q   <= `RXFD_RST_WORD;
      ptr_q   <= `RXFD_RST_WORD;
      dma_q   <= RXFD_DMA_IDLE;
      done_q  <= 1'b0;
      store_q <= 1'b0;
      drop_q  <= 1'b0;
    end else begin
      cfg_q   <= wr_cfg ? {2'b00, wdata_i[5:0]} : cfg_q;
      stat_q  <= stat_d;
      rdata_q <= rd_i ? rdata_d : rdata_q;
      cnt_q   <= cnt_d;
      ptr_q   <= ptr_d;
      dma_q   <= dma_d;
      done_q  <= done_d;
      store_q <= frame_end_i & keep;
      drop_q  <= frame_end_i & ~keep;
    end
  end

  assign rdata_o  = rdata_q;
  assign addr_o   = ptr_q;
  assign active_o = dma_q;
  assign done_o   = done_q;
  assign store_o  = store_q;
  assign drop_o   = drop_q;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_cnt_low_load: assert property (wr_cnt_lo & ~start_i & (dma_q == RXFD_DMA_IDLE) |=> cnt_q[7:0] == $past(wdata_i))
    else $error("count low byte not loaded");
  a_ptr_read: assert property (rd_i & (addr_i == `RXFD_OFS_PTR_HIGH) |=> rdata_o == $past(addr_o[15:8]))
    else $error("pointer high byte read wrong");
  a_ptr_step: assert property (run_step & ~word_i |=> addr_o == 16'($past(addr_o) + 16'h0001))
    else $error("pointer did not advance by one");
  a_ptr_start: assert property (start_i & ~active_o |=> addr_o == $past(origin_i))
    else $error("pointer not loaded at start");
  a_done_set: assert property (run_step & last |=> done_o & ~active_o)
    else $error("done flag missing after last step");
  a_done_hold: assert property (done_o & ~wr_done |=> done_o)
    else $error("done flag lost without a clear");
  a_watch_nostore: assert property (frame_end_i & cfg_q[`RXFD_CFG_WATCH] |=> ~store_o)
    else $error("frame stored in watch-only mode");
  a_bcast_take: assert property (frame_end_i & bcast_i & cfg_q[`RXFD_CFG_BCAST] & rx_on_i & room_i & ~short_i
                                 & ~fcs_err_i & ~align_err_i & ~cfg_q[`RXFD_CFG_WATCH] |=> store_o)
    else $error("broadcast frame not stored");
  a_stat_zero: assert property (stat_q[3] == 1'b0 && stat_q[7] == 1'b0)
    else $error("status constant bits not zero");
  a_unmatched_drop: assert property (frame_end_i & ~match |=> drop_o & ~store_o)
    else $error("unmatched frame not dropped");
  a_word_step: assert property (run_step & word_i |=> addr_o == 16'($past(addr_o) + 16'h0002))
    else $error("pointer did not advance by two");
  a_ptr_hold: assert property (~start_i & ~run_step |=> $stable(addr_o))
    else $error("pointer moved without a step");
  a_start_run: assert property (start_i & ~active_o & (cnt_q != `RXFD_RST_WORD) |=> active_o)
    else $error("transfer did not start");
  a_done_clear: assert property (done_o & wr_done & ~finish |=> ~done_o)
    else $error("done flag not cleared");
  a_rdata_hold: assert property (~rd_i |=> $stable(rdata_o))
    else $error("read data changed without a read");
  a_short_drop: assert property (frame_end_i & short_i & ~cfg_q[`RXFD_CFG_SHORT] |=> ~store_o)
    else $error("short frame stored");
  a_err_drop: assert property (frame_end_i & (fcs_err_i | align_err_i) & ~cfg_q[`RXFD_CFG_KEEPERR] |=> ~store_o)
    else $error("errored frame stored");
  a_mcast_hash: assert property (frame_end_i & mcast_i & ~hash_hit_i & ~unicast_i & ~bcast_i |=> ~store_o)
    else $error("multicast frame stored without a hash hit");
  a_stat_off: assert property (frame_end_i & ~rx_on_i |=> stat_q[`RXFD_ST_OFF] & ~stat_q[`RXFD_ST_OK])
    else $error("receiver off not reported");
  a_store_excl: assert property (~(store_o & drop_o))
    else $error("frame both stored and dropped");

endmodule : rxfd_regs

// *** rtl/rxfd_cfg.svh ***
// constants for the receive filter and remote transfer register bank
// assumes an 8-bit host register port with a 4-bit offset on one clock
//
// Summary of operation
// - The host writes the 16-bit transfer byte count as a low byte and a high byte, both write-only.
// - The live 16-bit transfer address reads back as a high byte and a low byte, both read-only.
// - Both live address bytes read zero after reset and always show the address now in use.
// - With watch-only set a frame is still address- and CRC-checked but never stored; clear is normal.
// - With any-unicast set every frame with an individual destination address is accepted.
// - With multicast-accept set a multicast frame is taken only when it also hits the hash filter.
// - With broadcast-accept set frames to the broadcast destination are accepted.
// - With short-frame-accept set frames below the minimum length are accepted.
// - With keep-errored-frames set frames with errors are accepted and stored, not dropped.
// - The status byte shows receiver off, multicast, missed, zero, alignment, CRC and intact, resetting to zero.
// - The transfer-done flag sets when a transfer ends and is cleared by writing one to it.
`ifndef RXFD_CFG_SVH
`define RXFD_CFG_SVH

// ==========================================
// register offsets
`define RXFD_OFS_DONE      4'h7
`define RXFD_OFS_PTR_LOW   4'h8
`define RXFD_OFS_PTR_HIGH  4'h9
`define RXFD_OFS_CNT_LOW   4'ha
`define RXFD_OFS_CNT_HIGH  4'hb
`define RXFD_OFS_RX_CFG    4'hc
`define RXFD_OFS_RX_STAT   4'hc

// ==========================================
// field positions
`define RXFD_DONE_BIT      6
`define RXFD_CFG_WATCH     5
`define RXFD_CFG_UNICAST   4
`define RXFD_CFG_MCAST     3
`define RXFD_CFG_BCAST     2
`define RXFD_CFG_SHORT     1
`define RXFD_CFG_KEEPERR   0
`define RXFD_ST_OFF        6
`define RXFD_ST_MCAST      5
`define RXFD_ST_MISSED     4
`define RXFD_ST_ALIGN      2
`define RXFD_ST_FCS        1
`define RXFD_ST_OK         0

// ==========================================
// reset values
`define RXFD_RST_BYTE      8'h00
`define RXFD_RST_WORD      16'h0000

`endif

// *** rtl/rxfd_pkg.sv ***
// types shared by the receive filter and remote transfer register bank
// assumes nothing beyond the constants header
package rxfd_pkg;

  typedef logic [7:0]  rxfd_byte_t;
  typedef logic [15:0] rxfd_word_t;
  typedef logic [3:0]  rxfd_ofs_t;

  typedef enum logic {
    RXFD_DMA_IDLE = 1'b0,
    RXFD_DMA_RUN  = 1'b1
  } rxfd_dma_e;

endpackage : rxfd_pkg

// *** rtl/rxfd_addr_filter.sv ***
// frame acceptance decision from destination class, errors and configuration
// assumes all inputs are stable in the cycle the frame end is flagged
`timescale 1ns/1ps
`include "rxfd_cfg.svh"
module rxfd_addr_filter (
  // configuration
  input  wire logic [7:0] cfg_i,
  // frame summary
  input  wire logic       own_addr_i,
  input  wire logic       unicast_i,
  input  wire logic       bcast_i,
  input  wire logic       mcast_i,
  input  wire logic       hash_hit_i,
  input  wire logic       short_i,
  input  wire logic       fault_i,
  input  wire logic       room_i,
  input  wire logic       rx_on_i,
  // decision
  output logic            match_o,
  output logic            store_o
);
  wire logic uni_ok   = unicast_i & (own_addr_i | cfg_i[`RXFD_CFG_UNICAST]);
  wire logic mc_ok    = mcast_i & cfg_i[`RXFD_CFG_MCAST] & hash_hit_i;
  wire logic bc_ok    = bcast_i & cfg_i[`RXFD_CFG_BCAST];
  wire logic len_ok   = ~short_i | cfg_i[`RXFD_CFG_SHORT];
  wire logic err_ok   = ~fault_i | cfg_i[`RXFD_CFG_KEEPERR];

  assign match_o = rx_on_i & (uni_ok | mc_ok | bc_ok);
  // watch-only still checks the frame but never commits it to the buffer
  assign store_o = match_o & len_ok & err_ok & room_i & ~cfg_i[`RXFD_CFG_WATCH];

endmodule : rxfd_addr_filter

// *** verif/rxfd_mover.sv ***
// data port mover model: issues one move per step while a transfer is running
// assumes the bench and the register bank share ref_clk_i; drives on the falling edge
`timescale 1ns/1ps
module rxfd_mover (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  // control from bench and register bank
  input  wire logic       active_i,
  input  wire logic       wide_i,
  input  wire logic [3:0] gap_i,
  // moves towards the register bank
  output logic            step_o,
  output logic            word_o
);
  logic [3:0] wait_q;

  // ==========================================
  // step pacing: gap_i plus one idle cycles between moves, zero gives every other cycle
  always @(negedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (step_o) begin
      step_o <= 1'b0;
      wait_q <= gap_i;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else begin
      step_o <= active_i;
    end
  end

  // width is only meaningful with a step, so show the wrong width otherwise
  assign word_o = step_o ? wide_i : ~wide_i;
endmodule : rxfd_mover

// *** verif/rxfd_regs_bench.sv ***
// self-checking bench for the receive filter and remote transfer register bank
// assumes the design files and rxfd_mover are compiled first
`timescale 1ns/1ps
module rxfd_regs_bench;
  import rxfd_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [15:0] origin_i = 16'h0000;
  logic start_i = 1'b0;
  logic frame_end_i = 1'b0;
  logic [9:0] fl = 10'h000;
  logic wide = 1'b0;
  logic [3:0] gap = 4'h0;
  logic step_i, word_i, active_o, done_o, store_o, drop_o;
  rxfd_byte_t rdata_o;
  rxfd_word_t addr_o;
  int fails = 0;
  int samples_checked = 0;

  rxfd_regs u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .origin_i(origin_i), .start_i(start_i), .step_i(step_i),
    .word_i(word_i), .addr_o(addr_o), .active_o(active_o), .done_o(done_o), .frame_end_i(frame_end_i),
    .own_addr_i(fl[0]), .unicast_i(fl[1]), .bcast_i(fl[2]), .mcast_i(fl[3]), .hash_hit_i(fl[4]),
    .short_i(fl[5]), .fcs_err_i(fl[6]), .align_err_i(fl[7]), .room_i(fl[8]), .rx_on_i(fl[9]),
    .store_o(store_o), .drop_o(drop_o));
  rxfd_mover u_mover (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .active_i(active_o), .wide_i(wide),
    .gap_i(gap), .step_o(step_i), .word_o(word_i));

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge ref_clk_i);
    wr_i = 1'b0;
  endtask : wr_reg

  // read data lands one edge after the strobe, so sample at the following falling edge
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mk);
    @(negedge ref_clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge ref_clk_i);
    rd_i = 1'b0;
    check($sformatf("read %h", a), {8'h00, exp & mk}, {8'h00, rdata_o & mk});
  endtask : rd_reg

  task automatic xfer(input logic [15:0] org, input logic [15:0] cnt, input logic w, input logic [15:0] fin);
    int n;
    wr_reg(4'hb, cnt[15:8]);
    wr_reg(4'ha, cnt[7:0]);
    wide = w;
    gap = w ? 4'h0 : 4'h3;
    origin_i = org;
    @(negedge ref_clk_i);
    start_i = 1'b1;
    @(negedge ref_clk_i);
    start_i = 1'b0;
    origin_i = ~org;
    for (n = 0; n < 3000 && done_o !== 1'b1; n++) @(negedge ref_clk_i);
    if (n == 3000) begin
      fails++;
      print_verdict();
    end
    check("end address", fin, addr_o);
    check("active", 16'h0000, {15'h0000, active_o});
    check("done", 16'h0001, {15'h0000, done_o});
    wr_reg(4'h8, 8'hff);
    rd_reg(4'h8, fin[7:0], 8'hff);
    rd_reg(4'h9, fin[15:8], 8'hff);
    rd_reg(4'h7, 8'h40, 8'hff);
    wr_reg(4'h7, 8'h40);
    rd_reg(4'h7, 8'h00, 8'hff);
  endtask : xfer

  task automatic frame(input logic [7:0] cfg, input logic [9:0] f, input logic s, input logic [7:0] rs,
                       input logic [7:0] mk);
    wr_reg(4'hc, cfg);
    @(negedge ref_clk_i);
    fl = f;
    frame_end_i = 1'b1;
    @(negedge ref_clk_i);
    frame_end_i = 1'b0;
    fl = ~f;
    check("store", {15'h0000, s}, {15'h0000, store_o});
    check("drop", {15'h0000, ~s}, {15'h0000, drop_o});
    rd_reg(4'hc, rs, mk);
  endtask : frame

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ==========================================
  // main sequence
  initial begin
    repeat (5) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    rd_reg(4'h8, 8'h00, 8'hff);
    rd_reg(4'h9, 8'h00, 8'hff);
    rd_reg(4'hc, 8'h00, 8'hff);
    rd_reg(4'h7, 8'h00, 8'hff);
    wr_reg(4'ha, 8'h5a);
    rd_reg(4'ha, 8'h00, 8'hff);
    rd_reg(4'hb, 8'h00, 8'hff);
    rd_reg(4'hf, 8'h00, 8'hff);
    xfer(16'h4321, 16'h0000, 1'b0, 16'h4321);
    xfer(16'h12fe, 16'h0003, 1'b0, 16'h1301);
    xfer(16'h0200, 16'h0101, 1'b1, 16'h0302);
    frame(8'h04, 10'h304, 1'b1, 8'h01, 8'hff);
    frame(8'h00, 10'h304, 1'b0, 8'h01, 8'hff);
    frame(8'h10, 10'h302, 1'b1, 8'h01, 8'hff);
    frame(8'h00, 10'h302, 1'b0, 8'h01, 8'hff);
    frame(8'h08, 10'h318, 1'b1, 8'h21, 8'hff);
    frame(8'h08, 10'h308, 1'b0, 8'h21, 8'hff);
    frame(8'h02, 10'h323, 1'b1, 8'h00, 8'hff);
    frame(8'h00, 10'h323, 1'b0, 8'h00, 8'hff);
    frame(8'h01, 10'h343, 1'b1, 8'h02, 8'hff);
    frame(8'h00, 10'h3c3, 1'b0, 8'h06, 8'hff);
    frame(8'h20, 10'h303, 1'b0, 8'h01, 8'hff);
    frame(8'h00, 10'h203, 1'b0, 8'h10, 8'h10);
    frame(8'h00, 10'h103, 1'b0, 8'h40, 8'h40);
    print_verdict();
  end
endmodule : rxfd_regs_bench
